/* File: hdl/sbiop_pkg.sv */
/*
  sbiop_pkg: register offsets, reset values and widths for the
  six-bit general-purpose port.
  assumes: a 32-bit apb slave with byte addresses of 8 bits.
*/
package sbiop_pkg;

  // port width and bus widths
  localparam int PIN_W = 6;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;

  // register byte offsets
  localparam logic [7:0] OFS_PORT_PIN_VALUE = 8'h00;
  localparam logic [7:0] OFS_OUTPUT_LATCH = 8'h04;
  localparam logic [7:0] OFS_DIRECTION_CONTROL = 8'h08;
  localparam logic [7:0] OFS_ANALOG_SELECT = 8'h0C;
  localparam logic [7:0] OFS_WEAK_PULLUP_ENABLE = 8'h10;
  localparam logic [7:0] OFS_OPEN_DRAIN_ENABLE = 8'h14;
  localparam logic [7:0] OFS_SLEW_LIMIT_ENABLE = 8'h18;
  localparam logic [7:0] OFS_INPUT_THRESHOLD_SELECT = 8'h1C;

  // values after reset
  localparam logic [5:0] RST_OUTPUT_LATCH = 6'h00;
  localparam logic [5:0] RST_DIRECTION_CONTROL = 6'h3F;
  localparam logic [5:0] RST_ANALOG_SELECT = 6'h3F;
  localparam logic [5:0] RST_WEAK_PULLUP_ENABLE = 6'h00;
  localparam logic [5:0] RST_OPEN_DRAIN_ENABLE = 6'h00;
  localparam logic [5:0] RST_SLEW_LIMIT_ENABLE = 6'h00;
  localparam logic [5:0] RST_INPUT_THRESHOLD_SELECT = 6'h00;

  // field positions and fill values
  localparam int FLD_PIN_LSB = 0;
  localparam int FLD_PIN_MSB = 5;
  localparam int STRB_PIN_BYTE = 0;
  localparam logic [25:0] UNUSED_ZERO = 26'h000_0000;
  localparam logic [5:0] ALL_PINS = 6'h3F;
  localparam logic [5:0] NO_PINS = 6'h00;

  // bus answer timing in cycles from the setup edge
  localparam int APB_ANSWER_CYCLES = 1;

endpackage : sbiop_pkg

/* File: hdl/sbiop_pin_cell.sv */
/*
  sbiop_pin_cell: output priority and input gating of one port pin.
  assumes: purely combinational; the caller registers every result.
*/
`timescale 1ns/1ps
module sbiop_pin_cell (
  // configuration of this pin
  input wire logic latch_bit,
  input wire logic dir_bit,
  input wire logic open_drain_bit,
  input wire logic analog_sel_bit,
  // other functions on this pin
  input wire logic router_sel,
  input wire logic router_out,
  input wire logic analog_out_en,
  // pad level and results
  input wire logic pin_level,
  output logic drv_oe,
  output logic drv_out,
  output logic dig_read
);

  logic src;
  logic drive;

  always_comb begin
    // latch unless the router claims the pin
    src = router_sel ? router_out : latch_bit;
    // direction alone enables the driver, analog select ignored
    drive = ~dir_bit;
    // analog output overrides every digital driver
    if (analog_out_en) begin
      drive = 1'b0;
    end
    // open drain only sinks, push-pull drives both ways
    if (open_drain_bit) begin
      drv_oe = drive & ~src;
      drv_out = 1'b0;
    end else begin
      drv_oe = drive;
      drv_out = src;
    end
    // analog pins read as zero
    dig_read = pin_level & ~analog_sel_bit;
  end

endmodule : sbiop_pin_cell

/* File: hdl/sbiop_port.sv */
/*
  sbiop_port: six-bit general-purpose port with apb register access.
  assumes: one clock, synchronous active-low reset, pad levels already
  synchronous to CLK, pad cells apply drive, pull-up, slew and
  threshold selections.
*/
// Functional notes
// - after reset no pin drives, all are inputs
// - analog inputs active only with analog select
// - digital outputs still drive analog pins
// - analog output wins and tristates driver
// - six pins each with own bits
// - direction one disables driver
// - direction zero drives selected source
// - port reads pins, writes go to latch
// - port write is read-modify-write into latch
// - latch holds most recent port write or strobed latch write
// - direction drives even analog pins
// - analog pins read digital zero
// - open drain only sinks current
// - open drain clear gives push-pull
// - slew bit limits pin edge rate
// - threshold bit picks schmitt or ttl
// - analog select never affects digital output
// - analog select resets to analog
// - each pin has own pull-up bit
// - other outputs only via router or analog
// - port register top bits read zero
// - direction bits reset to input
`timescale 1ns/1ps
module sbiop_port (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  // pad side
  input wire logic [5:0] PIN_IN,
  output logic [5:0] PIN_OUT,
  output logic [5:0] PIN_OE,
  output logic [5:0] PIN_PULLUP,
  output logic [5:0] PIN_SLEW_LIMIT,
  output logic [5:0] PIN_TTL_SEL,
  // peripheral pin router and analog functions
  input wire logic [5:0] ROUTER_SEL,
  input wire logic [5:0] ROUTER_OUT,
  input wire logic [5:0] ANALOG_OUT_EN,
  output logic [5:0] ANALOG_IN_EN,
  output logic [5:0] DIGITAL_IN
);

  // configuration registers
  logic [5:0] output_latch;
  logic [5:0] direction_control;
  logic [5:0] analog_select;
  logic [5:0] weak_pullup_enable;
  logic [5:0] open_drain_enable;
  logic [5:0] slew_limit_enable;
  logic [5:0] input_threshold_select;

  // bus decode
  logic setup_phase;
  logic access_done;
  logic wr_done;
  logic strb_lo;
  logic addr_hit;
  logic [5:0] wdata_pins;
  logic [31:0] next_prdata;

  // per-pin results
  logic [5:0] cell_oe;
  logic [5:0] cell_out;
  logic [5:0] port_pin_bits;

  assign setup_phase = PSEL & ~PENABLE;
  assign access_done = PSEL & PENABLE & PREADY;
  assign wr_done = access_done & PWRITE;
  assign strb_lo = PSTRB[sbiop_pkg::STRB_PIN_BYTE];
  assign wdata_pins = PWDATA[sbiop_pkg::FLD_PIN_MSB:sbiop_pkg::FLD_PIN_LSB];

  // one cell per pin
  genvar gi;
  generate
    for (gi = 0; gi < sbiop_pkg::PIN_W; gi = gi + 1) begin : g_pin
      sbiop_pin_cell u_cell (
        .latch_bit(output_latch[gi]),
        .dir_bit(direction_control[gi]),
        .open_drain_bit(open_drain_enable[gi]),
        .analog_sel_bit(analog_select[gi]),
        .router_sel(ROUTER_SEL[gi]),
        .router_out(ROUTER_OUT[gi]),
        .analog_out_en(ANALOG_OUT_EN[gi]),
        .pin_level(PIN_IN[gi]),
        .drv_oe(cell_oe[gi]),
        .drv_out(cell_out[gi]),
        .dig_read(port_pin_bits[gi])
      );
    end
  endgenerate

  // address decode and read mux
  always_comb begin
    addr_hit = 1'b1;
    next_prdata = {sbiop_pkg::UNUSED_ZERO, sbiop_pkg::NO_PINS};
    unique case (PADDR)
      sbiop_pkg::OFS_PORT_PIN_VALUE: begin
        next_prdata = {sbiop_pkg::UNUSED_ZERO, port_pin_bits};
      end
      sbiop_pkg::OFS_OUTPUT_LATCH: begin
        next_prdata = {sbiop_pkg::UNUSED_ZERO, output_latch};
      end
      sbiop_pkg::OFS_DIRECTION_CONTROL: begin
        next_prdata = {sbiop_pkg::UNUSED_ZERO, direction_control};
      end
      sbiop_pkg::OFS_ANALOG_SELECT: begin
        next_prdata = {sbiop_pkg::UNUSED_ZERO, analog_select};
      end
      sbiop_pkg::OFS_WEAK_PULLUP_ENABLE: begin
        next_prdata = {sbiop_pkg::UNUSED_ZERO, weak_pullup_enable};
      end
      sbiop_pkg::OFS_OPEN_DRAIN_ENABLE: begin
        next_prdata = {sbiop_pkg::UNUSED_ZERO, open_drain_enable};
      end
      sbiop_pkg::OFS_SLEW_LIMIT_ENABLE: begin
        next_prdata = {sbiop_pkg::UNUSED_ZERO, slew_limit_enable};
      end
      sbiop_pkg::OFS_INPUT_THRESHOLD_SELECT: begin
        next_prdata = {sbiop_pkg::UNUSED_ZERO, input_threshold_select};
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // bus answer: ready in the first access cycle
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= setup_phase;
      if (setup_phase) begin
        PRDATA <= PWRITE ? 32'h0000_0000 : next_prdata;
        PSLVERR <= ~addr_hit;
      end else begin
        PRDATA <= 32'h0000_0000;
        PSLVERR <= 1'b0;
      end
    end
  end

  // output latch written from either register
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      output_latch <= sbiop_pkg::RST_OUTPUT_LATCH;
    end else if (wr_done && PADDR == sbiop_pkg::OFS_PORT_PIN_VALUE) begin
      // pins read, addressed bits replaced, result into latch
      output_latch <= strb_lo ? wdata_pins : port_pin_bits;
    end else if (wr_done && PADDR == sbiop_pkg::OFS_OUTPUT_LATCH) begin
      if (strb_lo) begin
        output_latch <= wdata_pins;
      end
    end
  end

  // direction and analog select
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      direction_control <= sbiop_pkg::RST_DIRECTION_CONTROL;
      analog_select <= sbiop_pkg::RST_ANALOG_SELECT;
    end else if (wr_done && strb_lo) begin
      if (PADDR == sbiop_pkg::OFS_DIRECTION_CONTROL) begin
        direction_control <= wdata_pins;
      end
      if (PADDR == sbiop_pkg::OFS_ANALOG_SELECT) begin
        analog_select <= wdata_pins;
      end
    end
  end

  // pad option registers
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      weak_pullup_enable <= sbiop_pkg::RST_WEAK_PULLUP_ENABLE;
      open_drain_enable <= sbiop_pkg::RST_OPEN_DRAIN_ENABLE;
      slew_limit_enable <= sbiop_pkg::RST_SLEW_LIMIT_ENABLE;
      input_threshold_select <= sbiop_pkg::RST_INPUT_THRESHOLD_SELECT;
    end else if (wr_done && strb_lo) begin
      unique case (PADDR)
        sbiop_pkg::OFS_WEAK_PULLUP_ENABLE: begin
          weak_pullup_enable <= wdata_pins;
        end
        sbiop_pkg::OFS_OPEN_DRAIN_ENABLE: begin
          open_drain_enable <= wdata_pins;
        end
        sbiop_pkg::OFS_SLEW_LIMIT_ENABLE: begin
          slew_limit_enable <= wdata_pins;
        end
        sbiop_pkg::OFS_INPUT_THRESHOLD_SELECT: begin
          // glitch hazard left to software
          input_threshold_select <= wdata_pins;
        end
        default: begin
          weak_pullup_enable <= weak_pullup_enable;
        end
      endcase
    end
  end

  // registered pad drive
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      PIN_OUT <= sbiop_pkg::NO_PINS;
      PIN_OE <= sbiop_pkg::NO_PINS;
    end else begin
      PIN_OUT <= cell_out;
      PIN_OE <= cell_oe;
    end
  end

  // registered pad options
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      PIN_PULLUP <= sbiop_pkg::NO_PINS;
      PIN_SLEW_LIMIT <= sbiop_pkg::NO_PINS;
      PIN_TTL_SEL <= sbiop_pkg::NO_PINS;
    end else begin
      PIN_PULLUP <= weak_pullup_enable;
      PIN_SLEW_LIMIT <= slew_limit_enable;
      PIN_TTL_SEL <= input_threshold_select;
    end
  end

  // analog input enables and digital reads to peripherals
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ANALOG_IN_EN <= sbiop_pkg::NO_PINS;
      DIGITAL_IN <= sbiop_pkg::NO_PINS;
    end else begin
      ANALOG_IN_EN <= analog_select;
      DIGITAL_IN <= port_pin_bits;
    end
  end

  // checks
  property p_reset_values;
    @(posedge CLK) disable iff (!RST_N)
    $rose(RST_N) |-> (direction_control == sbiop_pkg::ALL_PINS)
      && (analog_select == sbiop_pkg::ALL_PINS)
      && (PIN_OE == sbiop_pkg::NO_PINS);
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("direction or analog select wrong after reset");

  property p_input_no_drive;
    @(posedge CLK) disable iff (!RST_N)
    1'b1 |=> ((PIN_OE & $past(direction_control)) == sbiop_pkg::NO_PINS);
  endproperty
  a_input_no_drive: assert property (p_input_no_drive)
    else $error("input pin has its driver enabled");

  property p_analog_out_wins;
    @(posedge CLK) disable iff (!RST_N)
    (ANALOG_OUT_EN != sbiop_pkg::NO_PINS)
      |=> ((PIN_OE & $past(ANALOG_OUT_EN)) == sbiop_pkg::NO_PINS);
  endproperty
  a_analog_out_wins: assert property (p_analog_out_wins)
    else $error("digital driver on while analog output enabled");

  property p_output_drives;
    @(posedge CLK) disable iff (!RST_N)
    1'b1 |=> ((PIN_OE | $past(direction_control) | $past(ANALOG_OUT_EN)
      | $past(open_drain_enable)) == sbiop_pkg::ALL_PINS);
  endproperty
  a_output_drives: assert property (p_output_drives)
    else $error("output pin not driven");

  property p_latch_source;
    @(posedge CLK) disable iff (!RST_N)
    (ROUTER_SEL == sbiop_pkg::NO_PINS && open_drain_enable == 6'h00)
      |=> (PIN_OUT == $past(output_latch));
  endproperty
  a_latch_source: assert property (p_latch_source)
    else $error("pin does not follow its latch");

  property p_open_drain;
    @(posedge CLK) disable iff (!RST_N)
    1'b1 |=> ((PIN_OUT & $past(open_drain_enable)) == sbiop_pkg::NO_PINS);
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open drain pin driven high");

  property p_analog_reads_zero;
    @(posedge CLK) disable iff (!RST_N)
    1'b1 |=> ((DIGITAL_IN & $past(analog_select)) == sbiop_pkg::NO_PINS);
  endproperty
  a_analog_reads_zero: assert property (p_analog_reads_zero)
    else $error("analog pin reads nonzero");

  property p_port_write;
    @(posedge CLK) disable iff (!RST_N)
    (wr_done && strb_lo && (PADDR == sbiop_pkg::OFS_PORT_PIN_VALUE
      || PADDR == sbiop_pkg::OFS_OUTPUT_LATCH))
      |=> (output_latch == $past(wdata_pins));
  endproperty
  a_port_write: assert property (p_port_write)
    else $error("latch missed a write");

  property p_rmw_keep;
    @(posedge CLK) disable iff (!RST_N)
    (wr_done && !strb_lo && PADDR == sbiop_pkg::OFS_PORT_PIN_VALUE)
      |=> (output_latch == $past(port_pin_bits));
  endproperty
  a_rmw_keep: assert property (p_rmw_keep)
    else $error("read-modify-write did not store pin levels");

  property p_port_read_top;
    @(posedge CLK) disable iff (!RST_N)
    (setup_phase && !PWRITE && PADDR == sbiop_pkg::OFS_PORT_PIN_VALUE)
      |=> PREADY && (PRDATA[31:6] == 26'h000_0000)
      && (PRDATA[5:0] == $past(port_pin_bits));
  endproperty
  a_port_read_top: assert property (p_port_read_top)
    else $error("port read returned wrong data");

  property p_pullup;
    @(posedge CLK) disable iff (!RST_N)
    1'b1 |=> (PIN_PULLUP == $past(weak_pullup_enable))
      ##1 (PIN_PULLUP == $past(weak_pullup_enable));
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("pull-up does not follow its enable");

  property p_analog_in;
    @(posedge CLK) disable iff (!RST_N)
    1'b1 |=> (ANALOG_IN_EN == $past(analog_select))
      && (PIN_SLEW_LIMIT == $past(slew_limit_enable))
      && (PIN_TTL_SEL == $past(input_threshold_select));
  endproperty
  a_analog_in: assert property (p_analog_in)
    else $error("analog enable or pad option lags wrongly");

endmodule : sbiop_port

/* File: testbench/sbiop_pad_model.sv */
/*
  sbiop_pad_model: pads and outside drivers around the port.
  assumes: fed by the port's pad outputs on the same clock.
*/
`timescale 1ns/1ps
module sbiop_pad_model (
  // clock
  input wire logic clk,
  // pad controls from the port
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe,
  input wire logic [5:0] pin_pullup,
  // outside drivers
  input wire logic [5:0] ext_en,
  input wire logic [5:0] ext_val,
  // pad level seen by the port
  output logic [5:0] pin_in
);
  logic [5:0] next_pin_in;
  initial pin_in = 6'h00;
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (pin_oe[i] === 1'b1) next_pin_in[i] = pin_out[i];
      else if (ext_en[i]) next_pin_in[i] = ext_val[i];
      else if (pin_pullup[i] === 1'b1) next_pin_in[i] = 1'b1;
      else next_pin_in[i] = ~pin_in[i]; // floating: keeps changing
    end
  end
  always @(posedge clk) pin_in <= next_pin_in;
endmodule : sbiop_pad_model

/* File: testbench/tb_top.sv */
/*
  tb_top: register and pad tests of the six-bit port.
  assumes: apb slave answering within a few cycles, pad model outside.
*/
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  logic pready, pslverr;
  logic [31:0] prdata;
  logic [5:0] pin_in, pin_out, pin_oe, pin_pullup, pin_slew, pin_ttl;
  logic [5:0] router_sel = 6'h00;
  logic [5:0] router_out = 6'h00;
  logic [5:0] aout_en = 6'h00;
  logic [5:0] ext_en = 6'h00;
  logic [5:0] ext_val = 6'h00;
  logic [5:0] ain_en, dig_in;
  int miscompares = 0;
  int cmp_count = 0;
  // reset values at 00,04,08,0C,10,14,18,1C
  logic [5:0] rst_tab [8] = '{6'h00, 6'h00, 6'h3F, 6'h3F,
                               6'h00, 6'h00, 6'h00, 6'h00};

  always #12.5 clk = ~clk;

  sbiop_port dut_u (.CLK(clk), .RST_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PSTRB(pstrb), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
    .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
    .PIN_PULLUP(pin_pullup), .PIN_SLEW_LIMIT(pin_slew),
    .PIN_TTL_SEL(pin_ttl), .ROUTER_SEL(router_sel),
    .ROUTER_OUT(router_out), .ANALOG_OUT_EN(aout_en),
    .ANALOG_IN_EN(ain_en), .DIGITAL_IN(dig_in));

  sbiop_pad_model pad_u (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val),
    .pin_in(pin_in));

  task automatic chk32(string nm, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask : chk32

  task automatic chk6(string nm, logic [5:0] e, logic [5:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask : chk6

  task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
                     logic [3:0] s, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) miscompares++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(logic [7:0] a, logic [5:0] v, logic [3:0] s = 4'h1);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, {26'h3FF_FFFF, v}, s, rd, err);
  endtask : wr

  task automatic rd_chk(string nm, logic [7:0] a, logic [5:0] e);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0000_0000, 4'h0, rd, err);
    chk32(nm, {26'h000_0000, e}, rd);
  endtask : rd_chk

  task automatic settle;
    repeat (4) @(posedge clk);
    #1;
  endtask : settle

  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    final_report();
  end

  initial begin
    logic [31:0] rd;
    logic err;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk6("oe_rst", 6'h00, pin_oe);
    chk6("ain_rst", 6'h3F, ain_en);
    for (int i = 0; i < 8; i++) begin
      rd_chk("reset_reg", 8'(i * 4), rst_tab[i]);
    end
    apb(1'b0, 8'h20, 32'h0000_0000, 4'h0, rd, err);
    chk32("unmapped_err", 32'h0000_0001, {31'h0000_0000, err});
    chk32("unmapped_rd", 32'h0000_0000, rd);
    $display("test reset done");
    wr(8'h0C, 6'h00);
    wr(8'h04, 6'h2A);
    wr(8'h08, 6'h00);
    settle();
    chk6("oe_all", 6'h3F, pin_oe);
    chk6("out_latch", 6'h2A, pin_out);
    @(posedge clk);
    ext_en <= 6'h30;
    ext_val <= 6'h30;
    wr(8'h08, 6'h30);
    settle();
    chk6("oe_dir", 6'h0F, pin_oe);
    chk6("dig_in", 6'h3A, dig_in);
    rd_chk("port_rd", 8'h00, 6'h3A);
    $display("test direction done");
    wr(8'h00, 6'h00, 4'h0);
    rd_chk("rmw_latch", 8'h04, 6'h3A);
    wr(8'h00, 6'h15);
    rd_chk("latch_port_wr", 8'h04, 6'h15);
    settle();
    rd_chk("port_pins", 8'h00, 6'h35);
    wr(8'h04, 6'h0A);
    rd_chk("latch_wr", 8'h04, 6'h0A);
    wr(8'h04, 6'h3F, 4'h0);
    rd_chk("latch_nostrb", 8'h04, 6'h0A);
    $display("test latch done");
    wr(8'h0C, 6'h03);
    settle();
    chk6("oe_analog", 6'h0F, pin_oe);
    chk6("ain_en", 6'h03, ain_en);
    chk6("dig_analog", 6'h38, dig_in);
    rd_chk("port_analog", 8'h00, 6'h38);
    @(posedge clk);
    aout_en <= 6'h01;
    settle();
    chk6("oe_aout", 6'h0E, pin_oe);
    @(posedge clk);
    aout_en <= 6'h00;
    router_sel <= 6'h02;
    settle();
    chk6("out_router", 6'h08, pin_out & 6'h0F);
    chk6("oe_router", 6'h0F, pin_oe);
    @(posedge clk);
    router_sel <= 6'h00;
    $display("test analog done");
    wr(8'h14, 6'h3F);
    settle();
    chk6("od_out", 6'h00, pin_out & 6'h0F);
    chk6("od_oe", 6'h05, pin_oe);
    wr(8'h14, 6'h00);
    settle();
    chk6("pp_oe", 6'h0F, pin_oe);
    chk6("pp_out", 6'h0A, pin_out & 6'h0F);
    $display("test drive done");
    wr(8'h10, 6'h15);
    wr(8'h18, 6'h2A);
    wr(8'h1C, 6'h33);
    settle();
    chk6("pullup", 6'h15, pin_pullup);
    chk6("slew", 6'h2A, pin_slew);
    chk6("ttl", 6'h33, pin_ttl);
    rd_chk("thr_rd", 8'h1C, 6'h33);
    wr(8'h10, 6'h00);
    settle();
    chk6("pullup_off", 6'h00, pin_pullup);
    $display("test pad controls done");
    final_report();
  end
endmodule : tb_top
